// file: core/tdm_bus_clock_master_ctrl.sv
// Purpose: Backplane clock drive, role, tracking and stream rate control
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Link pins are sampled by mclk; generated clocks are mclk based

`timescale 1ns/10ps
`default_nettype none

// Contract
// R1 - Drive bit 0 enables pair A clock and frame pin drivers.
// R2 - Drive bit 1 enables pair B clock and frame pin drivers.
// R3 - Drive bit 2 enables the legacy compatibility outputs as a group.
// R4 - Drive bits 4:3 always read zero.
// R5 - Drive bit 5 sets compat frame pulse active level.
// R6 - Drive bits 7:6 place the pulse: straddle, last bit, first bit.
// R7 - Drive bits 9:8 set pulse width by 2, 4 or 8 MHz clock.
// R8 - Drive bit 10 inverts the compat bit clock.
// R9 - Drive bit 11 inverts the compat double clock.
// R10 - Drive bits 13:12 pick compat clock rate 2, 4 or 8 MHz.
// R11 - Software writes zero to drive bits 15:14.
// R12 - Role bits 1:0 pick backup or master on pair A or B.
// R13 - Role has no effect while all drive enables are off.
// R14 - Track bits 3:2 code 00 tracks A, 01 tracks B.
// R15 - Codes 10 and 11 track A or B and fail over.
// R16 - Software writes zero to role bits 15:4.
// R17 - Rate register field k sets rate of streams 4k to 4k+3.
// R18 - Software avoids reserved code 11 in timing and rate fields.
module tdm_bus_clock_master_ctrl
  import tdm_clk_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Backplane pair A
  input  wire logic        bus_clock_a_in,
  output logic             bus_clock_a_out,
  output logic             bus_clock_a_oe_n,
  input  wire logic        bus_frame_a_in,
  output logic             bus_frame_a_out,
  output logic             bus_frame_a_oe_n,
  // Backplane pair B
  input  wire logic        bus_clock_b_in,
  output logic             bus_clock_b_out,
  output logic             bus_clock_b_oe_n,
  input  wire logic        bus_frame_b_in,
  output logic             bus_frame_b_out,
  output logic             bus_frame_b_oe_n,
  // Legacy compatibility outputs
  output logic             compat_bit_clock,
  output logic             compat_double_clock,
  output logic             compat_frame_pulse,
  output logic             compat_oe_n,
  // Stream rates and tracking state
  output logic      [63:0] stream_rate,
  output logic             tracking_b
);

  typedef struct packed {
    logic [15:0]     drive;
    logic [15:0]     role;
    logic [15:0]     rates;
    logic [15:0]     rdata;
    track_state_type trk;
    logic [14:0]     fcnt;
    logic [4:0]      c8cnt;
    logic            c8;
    logic            fr;
    logic [6:0]      qcnt;
    logic [1:0]      ph;
    logic            sclk;
    logic            dbl;
    logic            pulse;
  } state_type;

  localparam logic [14:0] FRAME_LAST = 15'(FRAME_CYCLES - 1);
  localparam logic [14:0] FR_HALF    = 15'(C8_HALF);
  localparam logic [4:0]  C8_LAST    = 5'(C8_HALF - 1);

  state_type s;
  state_type next_s;

  edge_track_if trk_a ();
  edge_track_if trk_b ();

  logic        any_drive;
  logic        backup;
  logic        resync;
  logic        trk_frame;
  logic [14:0] pw;
  logic [14:0] pw_half;

  // Quarter period of the compat bit clock for a rate code
  function automatic logic [6:0] quarter_cyc(input logic [1:0] code);
    logic [6:0] q;
    q = 7'(Q2M_CYC);
    if (code == RATE_4M)
      q = 7'(Q4M_CYC);
    else if (code == RATE_8M)
      q = 7'(Q8M_CYC);
    return q;
  endfunction : quarter_cyc

  assign trk_a.clk_pin   = bus_clock_a_in;
  assign trk_a.frame_pin = bus_frame_a_in;
  assign trk_b.clk_pin   = bus_clock_b_in;
  assign trk_b.frame_pin = bus_frame_b_in;

  bus_edge_tracker u_trk_a (
    .mclk   (mclk),
    .arst_n (arst_n),
    .link   (trk_a.tracker)
  );

  bus_edge_tracker u_trk_b (
    .mclk   (mclk),
    .arst_n (arst_n),
    .link   (trk_b.tracker)
  );

  // Role only matters once some output is driven
  assign any_drive = s.drive[DRV_A] || s.drive[DRV_B] ||
                     s.drive[DRV_COMP];                          // [R13]
  assign backup    = !s.role[ROLE_LO + 1];                       // [R12]
  // Role bit 0 names the pair that a backup stays in phase with
  assign trk_frame = s.role[ROLE_LO] ? trk_b.frame_start
                                     : trk_a.frame_start;        // [R12]
  // A backup follows its pair's frame so it can take over in phase
  assign resync    = any_drive && backup && trk_frame;           // [R13]
  // Pulse width is one bit period of the chosen pulse clock
  assign pw        = {6'h00, quarter_cyc(s.drive[PRATE_LO +: 2]),
                      2'b00};                                    // [R7]
  assign pw_half   = {1'b0, pw[14:1]};

  always_comb
  begin
    next_s       = s;
    next_s.rdata = 16'h0000;

    if (reg_wr)
    begin
      if (reg_addr == OFF_DRIVE)
        next_s.drive = reg_wdata & ~(16'h0003 << RSV_LO);        // [R4]
      else if (reg_addr == OFF_ROLE)
        next_s.role = reg_wdata;
      else if (reg_addr == OFF_RATES)
        next_s.rates = reg_wdata;
    end

    if (reg_rd)
    begin
      if (reg_addr == OFF_DRIVE)
        next_s.rdata = s.drive;                                  // [R4]
      else if (reg_addr == OFF_ROLE)
        next_s.rdata = s.role;
      else if (reg_addr == OFF_RATES)
        next_s.rdata = s.rates;
      else if (reg_addr == OFF_STATUS)
        next_s.rdata = {13'h0000, trk_b.lost, trk_a.lost,
                        s.trk == TRACK_B};
    end

    // Frame timer; a master free-runs, a backup re-phases
    if (resync || s.fcnt == FRAME_LAST)                          // [R12]
      next_s.fcnt = 15'h0000;
    else
      next_s.fcnt = s.fcnt + 15'h0001;

    // Backplane bit clock and active low frame straddling the boundary
    if (next_s.fcnt == 15'h0000)
    begin
      next_s.c8cnt = 5'h00;
      next_s.c8    = 1'b0;
    end
    else if (s.c8cnt == C8_LAST)
    begin
      next_s.c8cnt = 5'h00;
      next_s.c8    = !s.c8;
    end
    else
      next_s.c8cnt = s.c8cnt + 5'h01;
    next_s.fr = !(s.fcnt < FR_HALF || s.fcnt > FRAME_LAST - FR_HALF);

    // Compat clocks: double clock toggles each quarter, bit clock each half
    if (next_s.fcnt == 15'h0000)
    begin
      next_s.qcnt = 7'h00;
      next_s.ph   = 2'h0;
    end
    else if (s.qcnt == quarter_cyc(s.drive[SRATE_LO +: 2]) - 7'h01)
    begin                                                        // [R10]
      next_s.qcnt = 7'h00;
      next_s.ph   = s.ph + 2'h1;
    end
    else
      next_s.qcnt = s.qcnt + 7'h01;
    next_s.sclk = s.ph[1] ^ s.drive[SCLK_INV];                   // [R8]
    next_s.dbl  = s.ph[0] ^ s.drive[DBL_INV];                    // [R9]

    // Frame pulse placement and level; reserved placement stays idle
    case (s.drive[PLACE_LO +: 2])                                // [R6]
      PLACE_FIRST: next_s.pulse = s.fcnt < pw;
      PLACE_LAST:  next_s.pulse = s.fcnt > FRAME_LAST - pw;
      PLACE_STRAD: next_s.pulse = s.fcnt < pw_half ||
                                  s.fcnt > FRAME_LAST - pw_half;
      default:     next_s.pulse = 1'b0;
    endcase
    next_s.pulse = next_s.pulse ~^ s.drive[PULSE_POL];           // [R5]

    // Slave tracking with optional fail-over to the other pair
    case (s.role[TRACK_LO +: 2])
      TRK_A:    next_s.trk = TRACK_A;                            // [R14]
      TRK_B:    next_s.trk = TRACK_B;                            // [R14]
      TRK_A_FB: next_s.trk = (trk_a.lost && !trk_b.lost) ?
                             TRACK_B : TRACK_A;                  // [R15]
      default:  next_s.trk = (trk_b.lost && !trk_a.lost) ?
                             TRACK_A : TRACK_B;                  // [R15]
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{drive: RST_DRIVE, role: RST_ROLE, rates: RST_RATES,
             rdata: 16'h0000, trk: TRACK_A, fcnt: 15'h0000,
             c8cnt: 5'h00, c8: 1'b0, fr: 1'b1, qcnt: 7'h00,
             ph: 2'h0, sclk: 1'b0, dbl: 1'b0, pulse: 1'b1};
    else
      s <= next_s;
  end

  assign reg_rdata           = s.rdata;
  assign bus_clock_a_out     = s.c8;
  assign bus_frame_a_out     = s.fr;
  assign bus_clock_b_out     = s.c8;
  assign bus_frame_b_out     = s.fr;
  assign bus_clock_a_oe_n    = !s.drive[DRV_A];                  // [R1]
  assign bus_frame_a_oe_n    = !s.drive[DRV_A];                  // [R1]
  assign bus_clock_b_oe_n    = !s.drive[DRV_B];                  // [R2]
  assign bus_frame_b_oe_n    = !s.drive[DRV_B];                  // [R2]
  assign compat_oe_n         = !s.drive[DRV_COMP];               // [R3]
  assign compat_bit_clock    = s.sclk;
  assign compat_double_clock = s.dbl;
  assign compat_frame_pulse  = s.pulse;
  assign tracking_b          = s.trk == TRACK_B;

  // Each group field fans out to its four streams
  for (genvar i = 0; i < 32; i++)
  begin : g_rate
    assign stream_rate[2*i +: 2] = s.rates[2*(i/4) +: 2];        // [R17]
  end

  drive_a_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_wr && reg_addr == OFF_DRIVE |=>
    bus_clock_a_oe_n == !$past(reg_wdata[0]) &&
    bus_frame_a_oe_n == bus_clock_a_oe_n) // [R1]
    else $error("pair A drive does not follow written bit");

  drive_b_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_wr && reg_addr == OFF_DRIVE |=>
    bus_frame_b_oe_n == !$past(reg_wdata[1])) // [R2]
    else $error("pair B drive does not follow written bit");

  compat_drive_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_wr && reg_addr == OFF_DRIVE ##1 !reg_wr |=>
    compat_oe_n == !$past(reg_wdata[2], 2)) // [R3]
    else $error("compat drive does not follow written bit");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_rd && reg_addr == OFF_DRIVE |=> reg_rdata[4:3] == 2'b00) // [R4]
    else $error("reserved drive bits read nonzero");

  first_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.fcnt == 15'h0002 && $past(s.drive[7:5], 2) == 3'b101 |->
    compat_frame_pulse) // [R5]
    else $error("first bit pulse not active high");

  last_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.fcnt == 15'h0002 && $past(s.drive[7:5], 2) == 3'b010 |->
    compat_frame_pulse) // [R6]
    else $error("last bit low pulse active at frame start");

  no_role_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !any_drive && s.fcnt != FRAME_LAST |=>
    s.fcnt == $past(s.fcnt) + 15'h0001) // [R13]
    else $error("frame timer disturbed while not driving");

  fixed_track_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.role[3:2] == TRK_B ##1 s.role[3:2] == TRK_B |-> tracking_b) // [R14]
    else $error("fixed B tracking not held");

  failover_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.role[3:2] == TRK_A_FB && trk_a.lost && !trk_b.lost &&
    !(reg_wr && reg_addr == OFF_ROLE) |=> tracking_b) // [R15]
    else $error("no fail-over to pair B");

  group_rate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_wr && reg_addr == OFF_RATES |=>
    stream_rate[41:40] == $past(reg_wdata[11:10])) // [R17]
    else $error("stream 20 rate does not follow group field");

  failover_c: cover property (@(posedge mclk) disable iff (!arst_n)
    s.role[3:2] == TRK_A_FB ##1 tracking_b);
  resync_c: cover property (@(posedge mclk) disable iff (!arst_n)
    resync);
  frame_wrap_c: cover property (@(posedge mclk) disable iff (!arst_n)
    s.fcnt == FRAME_LAST && !compat_oe_n);

endmodule : tdm_bus_clock_master_ctrl

`default_nettype wire

// file: common/tdm_clk_pkg.sv
// Purpose: Shared constants for the TDM backplane clock control block
// Assumes: 250 MHz mclk; registers are 16 bits at their byte offsets
// Notes:   Times are in ns; cycle counts derive from them

package tdm_clk_pkg;

  // Register offsets
  localparam logic [11:0] OFF_DRIVE  = 12'h720;
  localparam logic [11:0] OFF_ROLE   = 12'h722;
  localparam logic [11:0] OFF_RATES  = 12'h730;
  localparam logic [11:0] OFF_STATUS = 12'h734;

  // Reset values
  localparam logic [15:0] RST_DRIVE = 16'h0200;
  localparam logic [15:0] RST_ROLE  = 16'h0002;
  localparam logic [15:0] RST_RATES = 16'haaaa;

  // Field positions in the drive configuration register
  localparam int DRV_A     = 0;
  localparam int DRV_B     = 1;
  localparam int DRV_COMP  = 2;
  localparam int RSV_LO    = 3;
  localparam int PULSE_POL = 5;
  localparam int PLACE_LO  = 6;
  localparam int PRATE_LO  = 8;
  localparam int SCLK_INV  = 10;
  localparam int DBL_INV   = 11;
  localparam int SRATE_LO  = 12;

  // Field positions in the role select register
  localparam int ROLE_LO  = 0;
  localparam int TRACK_LO = 2;

  // Field encodings
  localparam logic [1:0] RATE_4M     = 2'h1;
  localparam logic [1:0] RATE_8M     = 2'h2;
  localparam logic [1:0] PLACE_STRAD = 2'h0;
  localparam logic [1:0] PLACE_LAST  = 2'h1;
  localparam logic [1:0] PLACE_FIRST = 2'h2;
  localparam logic [1:0] TRK_A       = 2'h0;
  localparam logic [1:0] TRK_B       = 2'h1;
  localparam logic [1:0] TRK_A_FB    = 2'h2;
  localparam logic [1:0] TRK_B_FB    = 2'h3;

  // Timing
  localparam int MCLK_NS    = 4;
  localparam int C8_HALF_NS = 61;
  localparam int C8_HALF    = C8_HALF_NS / MCLK_NS;
  localparam int FRAME_NS   = 125000;
  localparam int FRAME_CYC  = FRAME_NS / MCLK_NS;
  localparam int LOSS_NS    = 1000;
  localparam int LOSS_CYC   = (LOSS_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int Q2M_NS     = 122;
  localparam int Q4M_NS     = 61;
  localparam int Q8M_NS     = 30;
  localparam int Q2M_CYC    = Q2M_NS / MCLK_NS;
  localparam int Q4M_CYC    = Q4M_NS / MCLK_NS;
  localparam int Q8M_CYC    = Q8M_NS / MCLK_NS;

  typedef enum logic [1:0]
  {
    TRACK_A = 2'b01,
    TRACK_B = 2'b10
  } track_state_type;

endpackage : tdm_clk_pkg

// file: common/edge_track_if.sv
// Purpose: Carries one backplane clock/frame pair to its tracker
// Assumes: Pin levels are asynchronous to mclk
// Notes:   One instance per pair

`timescale 1ns/10ps
`default_nettype none

interface edge_track_if;
  logic clk_pin;
  logic frame_pin;
  logic frame_start;
  logic lost;

  modport tracker (input clk_pin, frame_pin, output frame_start, lost);
  modport user    (output clk_pin, frame_pin, input frame_start, lost);
endinterface : edge_track_if

`default_nettype wire

// file: core/bus_edge_tracker.sv
// Purpose: Samples one clock/frame pair, flags frame starts and loss
// Assumes: Link clock much slower than mclk
// Notes:   Frame is active low; its falling edge starts a frame

`timescale 1ns/10ps
`default_nettype none

module bus_edge_tracker
  import tdm_clk_pkg::*;
(
  // Clock and reset
  input wire logic     mclk,
  input wire logic     arst_n,
  // Pair being watched
  edge_track_if.tracker link
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
    logic [7:0] idle;
    logic       lost;
    logic       start;
  } trk_type;

  localparam logic [7:0] LOSS_LAST = 8'(LOSS_CYC - 1);

  trk_type s;
  trk_type next_s;

  always_comb
  begin
    next_s       = s;
    next_s.s1    = {link.frame_pin, link.clk_pin};
    next_s.s2    = s.s1;
    next_s.prev  = s.s2;
    next_s.start = s.prev[1] && !s.s2[1];
    // A missing clock edge for the loss time marks the pair failed
    if (s.s2[0] != s.prev[0])
    begin
      next_s.idle = 8'h00;
      next_s.lost = 1'b0;
    end
    else if (s.idle == LOSS_LAST)
      next_s.lost = 1'b1;
    else
      next_s.idle = s.idle + 8'h01;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '{s1: 2'h3, s2: 2'h3, prev: 2'h3, idle: 8'h00,
             lost: 1'b1, start: 1'b0};
    else
      s <= next_s;
  end

  assign link.frame_start = s.start;
  assign link.lost        = s.lost;

  loss_time_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s.prev[0] == s.s2[0] && s.idle == LOSS_LAST |=> link.lost) // [R15]
    else $error("pair not flagged lost after loss time");

endmodule : bus_edge_tracker

`default_nettype wire

// file: verif/tdm_far_timing.sv
// Purpose: Far-side timing master that drives backplane pairs A and B
// Assumes: Backplane pins have pull-ups; link clock runs free
// Notes:   A stopped pair drives its pins high, the level the pull-ups would hold

`timescale 1ns/10ps
`default_nettype none

module tdm_far_timing #(
  parameter int HALF_NS    = 24,
  parameter int FRAME_BITS = 166
)
(
  // Bench controls
  input  wire logic run_a,
  input  wire logic run_b,
  // Backplane levels
  output logic      clk_a,
  output logic      frame_a,
  output logic      clk_b,
  output logic      frame_b
);
  logic link_clk;
  int   bit_cnt;
  logic frm;

  // Odd start offset keeps the link unrelated in phase to mclk
  initial
  begin
    link_clk = 1'b0;
    bit_cnt  = 0;
    #7;
    forever
    begin
      #(HALF_NS) link_clk = ~link_clk;
      if (link_clk)
        bit_cnt = (bit_cnt + 1) % FRAME_BITS;
    end
  end

  // Active-low frame, one bit wide, low for bit 0 just after the frame boundary
  assign frm = (bit_cnt != 0);

  always_comb
  begin
    clk_a   = run_a ? link_clk : 1'b1;
    frame_a = run_a ? frm : 1'b1;
    clk_b   = run_b ? link_clk : 1'b1;
    frame_b = run_b ? frm : 1'b1;
  end
endmodule : tdm_far_timing

`default_nettype wire

// file: verif/tdm_bus_clock_master_ctrl_tb_top.sv
// Purpose: Self-checking bench for the backplane clock control block
// Assumes: Short frame of 2000 mclk; far side modelled by tdm_far_timing
// Notes:   Pins resolve to the design's drive whenever its enable is low

`timescale 1ns/10ps
`default_nettype none

module tdm_bus_clock_master_ctrl_tb_top;
  import tdm_clk_pkg::*;
  localparam int FRM = 2000;
  // Frame of the far timing model in mclk cycles
  localparam int FAR_FRAME = 166 * 48 / MCLK_NS;
  logic        mclk, arst_n, reg_wr, reg_rd, run_a, run_b;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, rdv;
  logic [15:0] reg_rdata;
  logic        bus_clock_a_out, bus_clock_a_oe_n, bus_frame_a_out;
  logic        bus_frame_a_oe_n, bus_clock_b_out, bus_clock_b_oe_n;
  logic        bus_frame_b_out, bus_frame_b_oe_n, compat_bit_clock;
  logic        compat_double_clock, compat_frame_pulse, compat_oe_n;
  logic        tracking_b, fca, ffa, fcb, ffb;
  logic [63:0] stream_rate;
  wire logic   bus_clock_a_in, bus_frame_a_in;
  wire logic   bus_clock_b_in, bus_frame_b_in;
  int          err_count, comparisons, cycles;

  assign bus_clock_a_in = bus_clock_a_oe_n ? fca : bus_clock_a_out;
  assign bus_frame_a_in = bus_frame_a_oe_n ? ffa : bus_frame_a_out;
  assign bus_clock_b_in = bus_clock_b_oe_n ? fcb : bus_clock_b_out;
  assign bus_frame_b_in = bus_frame_b_oe_n ? ffb : bus_frame_b_out;

  tdm_bus_clock_master_ctrl #(.FRAME_CYCLES(FRM)) DUT
  (
    .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_clock_a_in, .bus_clock_a_out, .bus_clock_a_oe_n, .bus_frame_a_in,
    .bus_frame_a_out, .bus_frame_a_oe_n, .bus_clock_b_in, .bus_clock_b_out,
    .bus_clock_b_oe_n, .bus_frame_b_in, .bus_frame_b_out,
    .bus_frame_b_oe_n, .compat_bit_clock, .compat_double_clock,
    .compat_frame_pulse, .compat_oe_n, .stream_rate, .tracking_b
  );

  tdm_far_timing far
  (
    .run_a(run_a), .run_b(run_b), .clk_a(fca), .frame_a(ffa),
    .clk_b(fcb), .frame_b(ffb)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // Outputs launched by this edge settle before the caller looks
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic t_reset;
    rd(OFF_DRIVE); check(rdv, 16'h0200, "drive reset");
    rd(OFF_ROLE);  check(rdv, 16'h0002, "role reset");
    rd(OFF_RATES); check(rdv, 16'haaaa, "rates reset");
    check(stream_rate, {32{2'h2}}, "stream rate reset");
    check({compat_oe_n, bus_frame_a_oe_n, bus_frame_b_oe_n}, 3'h7,
          "oe at reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_drive;
    // Role codes must not move any pin while all enables are off
    for (int r = 0; r < 4; r++)
    begin
      wr(OFF_ROLE, 16'(r));
      repeat (20) @(posedge mclk);
      check({compat_oe_n, bus_clock_b_oe_n, bus_clock_a_oe_n}, 3'h7,
            "role moved pins");
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_DRIVE, 16'h0001 << i);
      check({compat_oe_n, bus_clock_b_oe_n, bus_clock_a_oe_n},
            3'(~(3'h1 << i)), "single enable");
      check({bus_frame_b_oe_n, bus_frame_a_oe_n},
            2'(~(3'h1 << i)), "frame follows");
    end
    wr(OFF_DRIVE, 16'h001f); // Software writes 00 to bits 15:14
    rd(OFF_DRIVE); check(rdv, 16'h0007, "reserved bits read");
    wr(OFF_DRIVE, 16'h0000);
    wr(OFF_ROLE, 16'h0002);
    $display("test drive done");
  endtask : t_drive

  task automatic t_regs;
    logic [15:0] v;
    v = 16'h4916; // No reserved code in any field
    wr(OFF_RATES, v);
    for (int i = 0; i < 32; i++)
      check(stream_rate[2*i+:2], v[2*(i/4)+:2], "stream rate");
    rd(OFF_RATES); check(rdv, v, "rates readback");
    wr(12'h724, 16'hffff);
    rd(12'h724); check(rdv, 16'h0000, "unmapped read");
    wr(OFF_STATUS, 16'hffff);
    rd(OFF_DRIVE); check(rdv, 16'h0000, "stray write landed");
    $display("test registers done");
  endtask : t_regs

  // Role value with tracking code t, master on A kept in bits 1:0
  task automatic role(input logic [1:0] t, input logic a, input logic b);
    wr(OFF_ROLE, {12'h000, t, 2'h2}); // Upper role bits zero
    run_a <= a;
    run_b <= b;
    repeat (400) @(posedge mclk);
  endtask : role

  task automatic t_track;
    role(TRK_A, 1, 1);    check(tracking_b, 1'b0, "track A");
    role(TRK_B, 1, 1);    check(tracking_b, 1'b1, "track B");
    role(TRK_A, 0, 1);    check(tracking_b, 1'b0, "no fail-over");
    role(TRK_A_FB, 0, 1); check(tracking_b, 1'b1, "A fails to B");
    rd(OFF_STATUS); check(rdv, 16'h0003, "status");
    role(TRK_A_FB, 1, 1); check(tracking_b, 1'b0, "A back");
    role(TRK_B_FB, 1, 1); check(tracking_b, 1'b1, "prefer B");
    role(TRK_B_FB, 1, 0); check(tracking_b, 1'b0, "B fails to A");
    run_b <= 1'b1;
    $display("test tracking done");
  endtask : t_track

  task automatic t_compat;
    int q, n, ok, p0;
    for (int r = 0; r < 3; r++)
    begin
      q = (r == 0) ? Q2M_CYC : (r == 1) ? Q4M_CYC : Q8M_CYC;
      // Placement 11 is reserved, so only 00 to 10 are set
      for (int p = 0; p < 3; p++)
      begin
        wr(OFF_DRIVE, 16'h0004 | 16'(r << 12) | 16'(r << 8) |
           16'(p << 6) | 16'(((p >> 1) & 1) << 5));
        repeat (FRM) @(posedge mclk);
        n = 0;
        repeat (FRM)
        begin
          @(posedge mclk);
          #1 if (compat_frame_pulse === 1'((p >> 1) & 1)) n++;
        end
        check(n, 4 * q, "pulse width");
      end
      // A frame restart may cut one period short, so two of three count
      ok = 0;
      @(posedge compat_bit_clock);
      for (int k = 0; k < 3; k++)
      begin
        p0 = 0;
        do
        begin
          @(posedge mclk);
          #1 p0++;
        end while (compat_bit_clock === 1'b1);
        do
        begin
          @(posedge mclk);
          #1 p0++;
        end while (compat_bit_clock === 1'b0);
        if (p0 == 4 * q) ok++;
      end
      check(ok >= 2, 1'b1, "bit clock period");
    end
    $display("test compat timing done");
  endtask : t_compat

  task automatic t_invert;
    logic [1:0] lv [2];
    for (int i = 0; i < 2; i++)
    begin
      wr(OFF_DRIVE, i ? 16'h0c04 : 16'h0004);
      repeat (FRM) @(posedge mclk);
      @(negedge compat_frame_pulse);
      #1 lv[i] = {compat_double_clock, compat_bit_clock};
    end
    check(lv[1][0], !lv[0][0], "bit clock invert");
    check(lv[1][1], !lv[0][1], "double clock invert");
    $display("test invert done");
  endtask : t_invert

  // A backup takes its frame period from pair A, not from its own timer
  task automatic t_backup;
    time t0;
    wr(OFF_ROLE, 16'h0000);
    wr(OFF_DRIVE, 16'h0084);
    repeat (2 * FRM) @(posedge mclk);
    @(negedge bus_frame_a_out);
    t0 = $time;
    @(negedge bus_frame_a_out);
    #1 check(bus_frame_b_out, 1'b0, "pair B frame");
    check(($time - t0) / MCLK_NS, FAR_FRAME, "backup period");
    repeat (100) @(posedge mclk);
    @(posedge bus_clock_b_out);
    t0 = $time;
    @(posedge bus_clock_b_out);
    #1 check(bus_clock_a_out, 1'b1, "pair A clock");
    check(($time - t0) / MCLK_NS, 2 * C8_HALF, "bus clock");
    $display("test backup done");
  endtask : t_backup

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 16'h0000;
    run_a     = 1'b1;
    run_b     = 1'b1;
    err_count = 0;
    comparisons = 0;
    cycles    = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_drive;
    t_regs;
    t_track;
    t_compat;
    t_invert;
    t_backup;
    tally_and_finish;
  end
endmodule : tdm_bus_clock_master_ctrl_tb_top

`default_nettype wire
